// *** rtl/dual_timer_counter_core.sv ***
// Two timer/counters on the special function register bus
// Assumes a single-cycle register bus and asynchronous port 3 pins
//
// Summary of operation
// - Timer on clock or counter on pin
// - 16-bit count as low/high bytes
// - Four modes, split for unit zero
// - Mode field selects 13,16,reload,split
// - Gate bit needs interrupt pin high
// - Clock source: divided clock or pin
// - Unit one upper nibble, zero lower
// - Event pins are port 3 bits 4,5
// - Run bit enables counting
// - Overflow sets flag, vector clears it
module dual_timer_counter_core
  import timer_pkg::*;
(
  // Clocking
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic clk_en,
  // Register bus
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_we,
  output logic [7:0] sfr_rdata,
  // Interrupt vector acknowledge
  input wire logic vector_ack_zero,
  input wire logic vector_ack_one,
  // Pins
  input wire logic [5:0] port3_in,
  // Flags out
  output logic overflow_flag_zero,
  output logic overflow_flag_one
);
  logic [7:0] timer_mode_select_reg;
  logic [7:0] clock_divider_control_reg;
  logic [7:0] count_zero_low_reg;
  logic [7:0] count_zero_high_reg;
  logic [7:0] count_one_low_reg;
  logic [7:0] count_one_high_reg;
  logic run_bit_zero_reg;
  logic run_bit_one_reg;
  logic [5:0] pin_meta_reg;
  logic [5:0] pin_sync_reg;
  logic [1:0] step;
  logic split_mode;
  logic [7:0] ctrl_read;
  logic zl_ovf, zh_ovf, ol_ovf, oh_ovf;
  logic ovf_zero, ovf_one;
  count_mode_type mode_zero, mode_one;
  default clocking cb_sys @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  // Two-stage pin synchronizer
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      pin_meta_reg <= 6'h3f;
      pin_sync_reg <= 6'h3f;
    end
    else if (clk_en)
    begin
      pin_meta_reg <= port3_in;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  function automatic count_mode_type mode_of(input logic [3:0] nib);
    mode_of = count_mode_type'({nib[MODE_HI_BIT], nib[MODE_LO_BIT]});
  endfunction : mode_of

  assign mode_zero = mode_of(timer_mode_select_reg[3:0]);
  assign mode_one = mode_of(timer_mode_select_reg[7:4]);
  assign split_mode = (mode_zero == MODE_SPLIT);

  generate
    for (genvar u = 0; u < 2; u++)
    begin : g_unit
      localparam int SH = u * UNIT_ONE_SHIFT;
      count_step_gen u_step
      (
        .clk_sys(clk_sys),
        .reset(reset),
        .clk_en(clk_en),
        .run_bit(u == 0 ? run_bit_zero_reg : run_bit_one_reg),
        .gate_en(timer_mode_select_reg[SH + GATE_BIT]),
        .src_sel(timer_mode_select_reg[SH + SRC_BIT]),
        .div_sel(clock_divider_control_reg[u == 0 ? DIV_ZERO_BIT
                                                  : DIV_ONE_BIT]),
        .irq_level(pin_sync_reg[u == 0 ? IRQ_ZERO_PIN
                                       : IRQ_ONE_PIN]),
        .event_level(pin_sync_reg[u == 0 ? EVENT_ZERO_PIN
                                         : EVENT_ONE_PIN]),
        .step(step[u])
      );
    end
  endgenerate

  function automatic logic low_wraps(input count_mode_type m,
                                     input logic [7:0] lo);
    low_wraps = (m == MODE_13) ? ((lo & LOW_13_MASK) == LOW_13_MASK)
                               : (lo == BYTE_ONES);
  endfunction : low_wraps

  // Overflow detection per byte
  assign zl_ovf = step[0] && low_wraps(mode_zero, count_zero_low_reg);
  assign zh_ovf = step[0] && !split_mode && mode_zero != MODE_RELOAD &&
                  zl_ovf && count_zero_high_reg == BYTE_ONES;
  // In split mode the high byte of unit zero runs on unit one's run bit
  assign oh_ovf = split_mode ? (run_bit_one_reg && step[1] &&
                                count_zero_high_reg == BYTE_ONES)
                             : 1'b0;
  assign ol_ovf = step[1] && mode_one != MODE_SPLIT &&
                  low_wraps(mode_one, count_one_low_reg);
  assign ovf_zero = (mode_zero == MODE_RELOAD || split_mode) ? zl_ovf
                                                              : zh_ovf;
  assign ovf_one = split_mode ? oh_ovf :
                   (mode_one == MODE_RELOAD) ? ol_ovf :
                   (ol_ovf && count_one_high_reg == BYTE_ONES &&
                    mode_one != MODE_SPLIT);

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      count_zero_low_reg <= BYTE_ZERO;
      count_zero_high_reg <= BYTE_ZERO;
    end
    else if (clk_en)
    begin
      if (sfr_we && sfr_addr == ADDR_ZERO_LOW)
        count_zero_low_reg <= sfr_wdata;
      else if (step[0])
      begin
        if (mode_zero == MODE_RELOAD && zl_ovf)
          count_zero_low_reg <= count_zero_high_reg;
        else if (mode_zero == MODE_13 && zl_ovf)
          count_zero_low_reg <= count_zero_low_reg & ~LOW_13_MASK;
        else
          count_zero_low_reg <= count_zero_low_reg + 8'h01;
      end
      if (sfr_we && sfr_addr == ADDR_ZERO_HIGH)
        count_zero_high_reg <= sfr_wdata;
      else if (split_mode ? (run_bit_one_reg && step[1])
               : (zl_ovf && mode_zero != MODE_RELOAD))
        count_zero_high_reg <= count_zero_high_reg + 8'h01;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      count_one_low_reg <= BYTE_ZERO;
      count_one_high_reg <= BYTE_ZERO;
    end
    else if (clk_en)
    begin
      if (sfr_we && sfr_addr == ADDR_ONE_LOW)
        count_one_low_reg <= sfr_wdata;
      else if (step[1] && mode_one != MODE_SPLIT && !split_mode)
      begin
        if (mode_one == MODE_RELOAD && ol_ovf)
          count_one_low_reg <= count_one_high_reg;
        else if (mode_one == MODE_13 && ol_ovf)
          count_one_low_reg <= count_one_low_reg & ~LOW_13_MASK;
        else
          count_one_low_reg <= count_one_low_reg + 8'h01;
      end
      if (sfr_we && sfr_addr == ADDR_ONE_HIGH)
        count_one_high_reg <= sfr_wdata;
      else if (ol_ovf && mode_one != MODE_RELOAD && !split_mode)
        count_one_high_reg <= count_one_high_reg + 8'h01;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      run_bit_zero_reg <= 1'b0;
      run_bit_one_reg <= 1'b0;
      timer_mode_select_reg <= BYTE_ZERO;
      clock_divider_control_reg <= BYTE_ZERO;
    end
    else if (clk_en && sfr_we)
    begin
      if (sfr_addr == ADDR_CONTROL)
      begin
        run_bit_zero_reg <= sfr_wdata[RUN_ZERO_BIT];
        run_bit_one_reg <= sfr_wdata[RUN_ONE_BIT];
      end
      if (sfr_addr == ADDR_MODE)
        timer_mode_select_reg <= sfr_wdata;
      if (sfr_addr == ADDR_CLK_DIV)
        clock_divider_control_reg <= sfr_wdata;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      overflow_flag_zero <= 1'b0;
      overflow_flag_one <= 1'b0;
    end
    else if (clk_en)
    begin
      if (ovf_zero)
        overflow_flag_zero <= 1'b1;
      else if (vector_ack_zero)
        overflow_flag_zero <= 1'b0;
      else if (sfr_we && sfr_addr == ADDR_CONTROL)
        overflow_flag_zero <= sfr_wdata[FLAG_ZERO_BIT];
      if (ovf_one)
        overflow_flag_one <= 1'b1;
      else if (vector_ack_one)
        overflow_flag_one <= 1'b0;
      else if (sfr_we && sfr_addr == ADDR_CONTROL)
        overflow_flag_one <= sfr_wdata[FLAG_ONE_BIT];
    end
  end

  always_comb
  begin
    ctrl_read = BYTE_ZERO;
    ctrl_read[FLAG_ONE_BIT] = overflow_flag_one;
    ctrl_read[RUN_ONE_BIT] = run_bit_one_reg;
    ctrl_read[FLAG_ZERO_BIT] = overflow_flag_zero;
    ctrl_read[RUN_ZERO_BIT] = run_bit_zero_reg;
  end

  // Registered read data
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      sfr_rdata <= BYTE_ZERO;
    else if (clk_en)
      unique case (sfr_addr)
        ADDR_CONTROL: sfr_rdata <= ctrl_read;
        ADDR_MODE: sfr_rdata <= timer_mode_select_reg;
        ADDR_ZERO_LOW: sfr_rdata <= count_zero_low_reg;
        ADDR_ONE_LOW: sfr_rdata <= count_one_low_reg;
        ADDR_ZERO_HIGH: sfr_rdata <= count_zero_high_reg;
        ADDR_ONE_HIGH: sfr_rdata <= count_one_high_reg;
        ADDR_CLK_DIV: sfr_rdata <= clock_divider_control_reg;
        default: sfr_rdata <= BYTE_ZERO;
      endcase
  end

  chk_flag_set_zero: assert property (
    clk_en && ovf_zero |=> overflow_flag_zero)
    else $error("flag zero not set");
  chk_flag_set_one: assert property (
    clk_en && ovf_one |=> overflow_flag_one)
    else $error("flag one not set");
  chk_ack_clear_zero: assert property (
    clk_en && vector_ack_zero && !ovf_zero |=> !overflow_flag_zero)
    else $error("flag zero not cleared");
  chk_run_hold_one: assert property (
    clk_en && !run_bit_one_reg && !split_mode && !sfr_we
    |=> $stable(count_one_low_reg))
    else $error("unit one moved while stopped");
  sequence reload_step;
    clk_en && !sfr_we && mode_zero == MODE_RELOAD && zl_ovf;
  endsequence
  chk_reload_zero: assert property (
    reload_step |=> count_zero_low_reg == $past(count_zero_high_reg))
    else $error("reload failed");
  chk_gate_block: assert property (
    timer_mode_select_reg[GATE_BIT] && !pin_sync_reg[IRQ_ZERO_PIN]
    |-> !step[0])
    else $error("gated unit stepped");
endmodule : dual_timer_counter_core

// *** rtl/timer_pkg.sv ***
// Constants for the dual timer/counter core
// Assumes an 8-bit special function register bus on the core clock
package timer_pkg;
  // Register addresses
  localparam logic [7:0] ADDR_CONTROL = 8'h88;
  localparam logic [7:0] ADDR_MODE = 8'h89;
  localparam logic [7:0] ADDR_ZERO_LOW = 8'h8a;
  localparam logic [7:0] ADDR_ONE_LOW = 8'h8b;
  localparam logic [7:0] ADDR_ZERO_HIGH = 8'h8c;
  localparam logic [7:0] ADDR_ONE_HIGH = 8'h8d;
  localparam logic [7:0] ADDR_CLK_DIV = 8'h8e;
  // Mode register fields, per-unit nibble
  localparam int UNIT_ONE_SHIFT = 4;
  localparam int GATE_BIT = 3;
  localparam int SRC_BIT = 2;
  localparam int MODE_HI_BIT = 1;
  localparam int MODE_LO_BIT = 0;
  // Control register fields
  localparam int FLAG_ONE_BIT = 7;
  localparam int RUN_ONE_BIT = 6;
  localparam int FLAG_ZERO_BIT = 5;
  localparam int RUN_ZERO_BIT = 4;
  // Clock divider control fields
  localparam int DIV_ZERO_BIT = 3;
  localparam int DIV_ONE_BIT = 4;
  // Event pin positions on port 3
  localparam int EVENT_ZERO_PIN = 4;
  localparam int EVENT_ONE_PIN = 5;
  // Interrupt pin positions on port 3
  localparam int IRQ_ZERO_PIN = 2;
  localparam int IRQ_ONE_PIN = 3;
  // Prescale last counts (divide by 4 and 12)
  localparam logic [3:0] DIV_FAST_LAST = 4'h3;
  localparam logic [3:0] DIV_SLOW_LAST = 4'hb;
  // Counter widths
  localparam logic [7:0] LOW_13_MASK = 8'h1f;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] BYTE_ONES = 8'hff;
  typedef enum logic [1:0]
  {
    MODE_13 = 2'b00,
    MODE_16 = 2'b01,
    MODE_RELOAD = 2'b10,
    MODE_SPLIT = 2'b11
  } count_mode_type;
endpackage : timer_pkg

// *** rtl/count_step_gen.sv ***
// Step generator for one unit: prescaler, event edge and gate
// Assumes pin inputs already synchronised by the caller
module count_step_gen
  import timer_pkg::*;
(
  // Clocking
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic clk_en,
  // Control
  input wire logic run_bit,
  input wire logic gate_en,
  input wire logic src_sel,
  input wire logic div_sel,
  input wire logic irq_level,
  input wire logic event_level,
  // Step out
  output logic step
);
  logic [3:0] div_reg;
  logic event_last_reg;
  logic tick;
  logic allowed;

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      div_reg <= 4'h0;
    else if (clk_en)
      div_reg <= (div_reg >= (div_sel ? DIV_FAST_LAST : DIV_SLOW_LAST))
                 ? 4'h0 : div_reg + 4'h1;
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      event_last_reg <= 1'b0;
    else if (clk_en)
      event_last_reg <= event_level;
  end

  assign allowed = run_bit && (!gate_en || irq_level);
  assign tick = src_sel ? (event_last_reg && !event_level)
                        : (div_reg == 4'h0);
  assign step = allowed && tick && clk_en;
endmodule : count_step_gen

// *** tb/sfr_core_model.sv ***
// Core side model: drives the special function register bus
// Assumes requests launched 1 ns after the rising clock edge
module sfr_core_model
(
  // Clock
  input wire logic clk_sys,
  // Register bus
  output logic [7:0] sfr_addr,
  output logic [7:0] sfr_wdata,
  output logic sfr_we,
  input wire logic [7:0] sfr_rdata,
  // Vector acknowledge
  output logic vector_ack_zero,
  output logic vector_ack_one
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    sfr_we = 1'b0;
    vector_ack_zero = 1'b0;
    vector_ack_one = 1'b0;
  end
  // Write held over one sampling edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    #1;
    sfr_addr = a;
    sfr_wdata = d;
    sfr_we = 1'b1;
    @(posedge clk_sys);
    #1;
    sfr_we = 1'b0;
    sfr_wdata = ~d;
  endtask : wr
  // Read data lands one cycle after the address
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    #1;
    sfr_addr = a;
    @(posedge clk_sys);
    #1;
    d = sfr_rdata;
  endtask : rd
  // One-cycle vector acknowledge
  task automatic ack(input logic unit);
    @(posedge clk_sys);
    #1;
    vector_ack_zero = !unit;
    vector_ack_one = unit;
    @(posedge clk_sys);
    #1;
    vector_ack_zero = 1'b0;
    vector_ack_one = 1'b0;
  endtask : ack
endmodule : sfr_core_model

// *** tb/dual_timer_counter_core_tb.sv ***
// Testbench for the dual timer/counter core
// Assumes a 10 MHz clock and the core bus model
module dual_timer_counter_core_tb
  import timer_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic clk_en = 1'b1;
  logic [5:0] port3_in = 6'h00;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, d;
  logic sfr_we, vector_ack_zero, vector_ack_one, flag_zero, flag_one;
  int n_fail = 0;
  int n_compared = 0;
  int cycles = 0;
  int n;
  always #50 clk_sys = ~clk_sys;
  dual_timer_counter_core i_dual_timer_counter_core (.clk_sys(clk_sys),
    .reset(reset), .clk_en(clk_en), .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata), .sfr_we(sfr_we), .sfr_rdata(sfr_rdata),
    .vector_ack_zero(vector_ack_zero), .vector_ack_one(vector_ack_one),
    .port3_in(port3_in), .overflow_flag_zero(flag_zero),
    .overflow_flag_one(flag_one));
  sfr_core_model i_sfr_core_model (.clk_sys(clk_sys), .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata), .sfr_we(sfr_we), .sfr_rdata(sfr_rdata),
    .vector_ack_zero(vector_ack_zero), .vector_ack_one(vector_ack_one));
  task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    i_sfr_core_model.rd(a, d);
    chk($sformatf("reg %h", a), e, d);
  endtask : rchk
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    i_sfr_core_model.wr(a, v);
  endtask : wr
  task automatic wait_flag(input logic unit);
    n = 0;
    while (((unit ? flag_one : flag_zero) !== 1'b1) && n < 80)
    begin
      @(posedge clk_sys);
      #1;
      n++;
    end
  endtask : wait_flag
  task automatic pulse(input int pin, input int k);
    repeat (k)
    begin
      @(posedge clk_sys);
      #1;
      port3_in[pin] = 1'b1;
      repeat (4) @(posedge clk_sys);
      #1;
      port3_in[pin] = 1'b0;
      repeat (5) @(posedge clk_sys);
      #1;
    end
  endtask : pulse
  task automatic t_regs;
    for (int i = 0; i < 5; i++)
      rchk(ADDR_MODE + 8'(i), 8'h00);
    for (int i = 1; i < 5; i++)
      wr(ADDR_MODE + 8'(i), 8'h5a + 8'(i));
    for (int i = 1; i < 5; i++)
      rchk(ADDR_MODE + 8'(i), 8'h5a + 8'(i));
    wr(ADDR_MODE, 8'hc6);
    rchk(ADDR_MODE, 8'hc6);
    rchk(8'h87, 8'h00);
    $display("t_regs done");
  endtask : t_regs
  task automatic t_timer16;
    wr(ADDR_CLK_DIV, 8'h08);
    wr(ADDR_ZERO_LOW, 8'hfc);
    wr(ADDR_ZERO_HIGH, 8'hff);
    wr(ADDR_MODE, 8'h01);
    wr(ADDR_CONTROL, 8'h10);
    wait_flag(1'b0);
    chk("cycles div4", 8'h01, 8'(n >= 13 && n <= 16));
    i_sfr_core_model.ack(1'b0);
    chk("flag zero", 8'h00, {7'h0, flag_zero});
    wr(ADDR_CONTROL, 8'h00);
    rchk(ADDR_ZERO_HIGH, 8'h00);
    chk("flag one", 8'h00, {7'h0, flag_one});
    $display("t_timer16 done");
  endtask : t_timer16
  task automatic t_reload;
    wr(ADDR_CLK_DIV, 8'h00);
    wr(ADDR_ZERO_HIGH, 8'h80);
    wr(ADDR_ZERO_LOW, 8'hfe);
    wr(ADDR_MODE, 8'h02);
    wr(ADDR_CONTROL, 8'h10);
    wait_flag(1'b0);
    chk("cycles div12", 8'h01, 8'(n >= 13 && n <= 24));
    wr(ADDR_CONTROL, 8'h00);
    rchk(ADDR_ZERO_LOW, 8'h80);
    rchk(ADDR_ZERO_HIGH, 8'h80);
    i_sfr_core_model.ack(1'b0);
    $display("t_reload done");
  endtask : t_reload
  task automatic t_event;
    wr(ADDR_MODE, 8'hdc);
    wr(ADDR_ZERO_LOW, 8'h00);
    wr(ADDR_ONE_LOW, 8'h00);
    wr(ADDR_CONTROL, 8'h50);
    pulse(EVENT_ZERO_PIN, 1);
    pulse(EVENT_ONE_PIN, 2);
    rchk(ADDR_ONE_LOW, 8'h00);
    port3_in[IRQ_ONE_PIN:IRQ_ZERO_PIN] = 2'b11;
    pulse(EVENT_ZERO_PIN, 2);
    pulse(EVENT_ONE_PIN, 3);
    rchk(ADDR_ONE_LOW, 8'h03);
    rchk(ADDR_ZERO_LOW, 8'h02);
    $display("t_event done");
  endtask : t_event
  task automatic t_mode13;
    wr(ADDR_MODE, 8'h40);
    wr(ADDR_ONE_LOW, 8'h1f);
    wr(ADDR_ONE_HIGH, 8'hff);
    pulse(EVENT_ONE_PIN, 1);
    chk("flag one", 8'h01, {7'h0, flag_one});
    rchk(ADDR_ONE_HIGH, 8'h00);
    i_sfr_core_model.rd(ADDR_ONE_LOW, d);
    chk("low five", 8'h00, d & LOW_13_MASK);
    i_sfr_core_model.ack(1'b1);
    chk("flag one clear", 8'h00, {7'h0, flag_one});
    wr(ADDR_CONTROL, 8'h00);
    $display("t_mode13 done");
  endtask : t_mode13
  task automatic t_split;
    wr(ADDR_CLK_DIV, 8'h18);
    wr(ADDR_ZERO_LOW, 8'h00);
    wr(ADDR_ZERO_HIGH, 8'hfe);
    wr(ADDR_MODE, 8'h03);
    wr(ADDR_CONTROL, 8'h40);
    wait_flag(1'b1);
    chk("cycles split", 8'h01, 8'(n >= 5 && n <= 8));
    chk("split flag", 8'h01, {7'h0, flag_one});
    chk("flag zero", 8'h00, {7'h0, flag_zero});
    wr(ADDR_CONTROL, 8'h00);
    rchk(ADDR_ZERO_LOW, 8'h00);
    $display("t_split done");
  endtask : t_split
  task automatic end_sim;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_sim
  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (cycles == 6000)
    begin
      n_fail++;
      end_sim();
    end
  end
  initial
  begin
    repeat (16) @(posedge clk_sys);
    #1;
    reset = 1'b0;
    t_regs();
    t_timer16();
    t_reload();
    t_event();
    t_mode13();
    t_split();
    end_sim();
  end
endmodule : dual_timer_counter_core_tb
